// >>> hw/mmp_pkg.sv
package mmp_pkg;
    localparam int ADDR_W = 16;
    localparam int DATA_W = 8;
    localparam int PORT_COUNT = 3;
    localparam int REGS_PER_PORT = 3;
    localparam int REG_COUNT = 9;
    localparam logic [3:0] IDX_DATA = 4'h0;
    localparam logic [3:0] IDX_DIRECTION = 4'h1;
    localparam logic [3:0] IDX_OPTION = 4'h2;
    localparam logic [3:0] IDX_PORT_A_DATA = 4'h0;
    localparam logic [3:0] IDX_PORT_A_DIRECTION = 4'h1;
    localparam logic [3:0] IDX_PORT_A_OPTION = 4'h2;
    localparam logic [3:0] IDX_PORT_B_DATA = 4'h3;
    localparam logic [3:0] IDX_PORT_B_DIRECTION = 4'h4;
    localparam logic [3:0] IDX_PORT_B_OPTION = 4'h5;
    localparam logic [3:0] IDX_PORT_C_DATA = 4'h6;
    localparam logic [3:0] IDX_PORT_C_DIRECTION = 4'h7;
    localparam logic [3:0] IDX_PORT_C_OPTION = 4'h8;
    localparam logic [7:0] RST_ZERO = 8'h00;
    localparam logic [7:0] RST_PORT_C_OPTION = 8'h08;
    localparam logic [15:0] REG_BASE = 16'h0000;
    localparam logic [15:0] REG_LAST = 16'h007F;
    localparam logic [15:0] RAM_BASE = 16'h0080;
    localparam logic [15:0] RAM_LAST = 16'h01FF;
    localparam logic [15:0] STACK_BASE = 16'h0180;
    localparam logic [15:0] STACK_LAST = 16'h01FF;
    localparam logic [15:0] VECT_BASE = 16'hFFE0;
    localparam logic [15:0] ADDR_TOP = 16'hFFFF;
    localparam logic [15:0] FLASH_8K_BASE = 16'hE000;
    localparam logic [15:0] FLASH_4K_BASE = 16'hF000;
    localparam logic [15:0] SECT0_DEFAULT_BASE = 16'hF000;
    localparam logic [15:0] MAP_RESERVED_LAST = 16'h007F;
    localparam logic [11:0] OFF_DECODE_ADDR = 12'h040;
    localparam logic [11:0] OFF_DECODE_RESULT = 12'h044;
    localparam logic [11:0] OFF_SECT0_BASE = 12'h048;
    localparam logic [11:0] OFF_FLASH_BASE = 12'h04C;
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;
    localparam int REGION_W = 8;
    localparam int RG_REG = 0;
    localparam int RG_RAM = 1;
    localparam int RG_STACK = 2;
    localparam int RG_FLASH = 3;
    localparam int RG_SECT0 = 4;
    localparam int RG_SECT1 = 5;
    localparam int RG_VECT = 6;
    localparam int RG_RSVD = 7;
endpackage

// >>> hw/mmp_dec_if.sv
`timescale 1ns/1ns
interface mmp_dec_if;
    logic [15:0] addr;
    logic [15:0] sect0_base;
    logic [15:0] flash_base;
    logic [7:0] region;
    modport dec (input addr, input sect0_base, input flash_base, output region);
    modport user (output addr, output sect0_base, output flash_base, input region);
endinterface

// >>> hw/mmp_decoder.sv
`timescale 1ns/1ns
module mmp_decoder (
    mmp_dec_if.dec d
);
    wire in_reg;
    wire in_ram;
    wire in_stack;
    wire in_flash;
    wire in_sect0;
    wire in_vect;
    assign in_reg = d.addr <= mmp_pkg::REG_LAST;
    assign in_ram = (d.addr >= mmp_pkg::RAM_BASE) && (d.addr <= mmp_pkg::RAM_LAST);
    assign in_stack = (d.addr >= mmp_pkg::STACK_BASE) && (d.addr <= mmp_pkg::STACK_LAST);
    assign in_flash = d.addr >= d.flash_base;
    assign in_sect0 = in_flash && (d.addr >= d.sect0_base);
    assign in_vect = d.addr >= mmp_pkg::VECT_BASE;
    assign d.region = {!(in_reg || in_ram || in_flash), in_vect && in_sect0, in_flash && !in_sect0,
                       in_sect0, in_flash, in_stack, in_ram, in_reg};
endmodule

// >>> hw/mmp_top.sv
// Contract
// - Decoder takes a 16-bit, 64 Kbyte address.
// - Register 128 bytes, RAM 384 bytes decoded.
// - Program Flash region 4 to 8 Kbytes.
// - Stack within RAM, 180h to 1FFh.
// - Two Flash sectors at top, sector zero highest.
// - Vectors FFE0h-FFFFh lie in sector zero.
// - Sector zero boundary set by option contents; the code takes it from sect0_base_reg, written at 048h, reset SECT0_BASE_RST.
// - Port A registers 0-2, reset 00h.
// - Port B registers 3-5, reset 00h.
// - Port C registers 6-8, option resets 08h.
`timescale 1ns/1ns
module mmp_top #(
    parameter logic [15:0] SECT0_BASE_RST = mmp_pkg::SECT0_DEFAULT_BASE,
    parameter logic [15:0] FLASH_BASE_RST = mmp_pkg::FLASH_8K_BASE
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic [11:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [11:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic [7:0] port_a_data_o,
    output logic [7:0] port_a_direction_o,
    output logic [7:0] port_a_option_o,
    output logic [7:0] port_b_data_o,
    output logic [7:0] port_b_direction_o,
    output logic [7:0] port_b_option_o,
    output logic [7:0] port_c_data_o,
    output logic [7:0] port_c_direction_o,
    output logic [7:0] port_c_option_o,
    output logic [7:0] region_o
);
    logic [7:0] regs_reg [mmp_pkg::REG_COUNT];
    logic [15:0] dec_addr_reg;
    logic [15:0] sect0_base_reg;
    logic [15:0] flash_base_reg;
    logic [7:0] region_reg;
    logic aw_held_reg;
    logic w_held_reg;
    logic [11:0] awaddr_reg;
    logic [31:0] wdata_reg;
    logic [3:0] wstrb_reg;
    logic bvalid_reg;
    logic [1:0] bresp_reg;
    logic rvalid_reg;
    logic [1:0] rresp_reg;
    logic [31:0] rdata_reg;

    mmp_dec_if dif ();
    assign dif.addr = dec_addr_reg;
    assign dif.sect0_base = sect0_base_reg;
    assign dif.flash_base = flash_base_reg;
    mmp_decoder u_dec (
        .d(dif.dec)
    );

    wire aw_hs;
    wire w_hs;
    wire ar_hs;
    wire wr_go;
    wire awready_next;
    wire wready_next;
    wire arready_next;
    wire [11:0] wa;
    wire [31:0] wd;
    wire [3:0] ws;
    assign aw_hs = s_axi_awvalid && s_axi_awready;
    assign w_hs = s_axi_wvalid && s_axi_wready;
    assign ar_hs = s_axi_arvalid && s_axi_arready;
    assign awready_next = s_axi_awvalid && !s_axi_awready && !aw_held_reg && !bvalid_reg;
    assign wready_next = s_axi_wvalid && !s_axi_wready && !w_held_reg && !bvalid_reg;
    assign arready_next = s_axi_arvalid && !s_axi_arready && !rvalid_reg;
    assign wa = awaddr_reg;
    assign wd = wdata_reg;
    assign ws = wstrb_reg;
    assign wr_go = aw_held_reg && w_held_reg && !bvalid_reg;

    wire [9:0] w_idx;
    wire w_is_port;
    wire w_is_ctl;
    wire w_hit;
    assign w_idx = wa[11:2];
    assign w_is_port = w_idx < 10'(mmp_pkg::REG_COUNT);
    assign w_is_ctl = (wa == mmp_pkg::OFF_DECODE_ADDR) || (wa == mmp_pkg::OFF_SECT0_BASE)
                      || (wa == mmp_pkg::OFF_FLASH_BASE) || (wa == mmp_pkg::OFF_DECODE_RESULT);
    assign w_hit = (wa[1:0] == 2'b00) && (w_is_port || w_is_ctl);
    wire w_port_we;
    assign w_port_we = wr_go && ws[0] && (wa[1:0] == 2'b00);

    wire [9:0] r_idx;
    wire r_is_port;
    logic [31:0] r_val;
    logic r_ok;
    assign r_idx = s_axi_araddr[11:2];
    assign r_is_port = (s_axi_araddr[1:0] == 2'b00) && (r_idx < 10'(mmp_pkg::REG_COUNT));
    always_comb begin
        r_val = 32'h0000_0000;
        r_ok = 1'b1;
        if (r_is_port) begin
            r_val = {24'h00_0000, regs_reg[r_idx[3:0]]};
        end else if (s_axi_araddr == mmp_pkg::OFF_DECODE_ADDR) begin
            r_val = {16'h0000, dec_addr_reg};
        end else if (s_axi_araddr == mmp_pkg::OFF_DECODE_RESULT) begin
            r_val = {24'h00_0000, region_reg};
        end else if (s_axi_araddr == mmp_pkg::OFF_SECT0_BASE) begin
            r_val = {16'h0000, sect0_base_reg};
        end else if (s_axi_araddr == mmp_pkg::OFF_FLASH_BASE) begin
            r_val = {16'h0000, flash_base_reg};
        end else begin
            r_ok = 1'b0;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            aw_held_reg <= 1'b0;
            awaddr_reg <= 12'h000;
        end else if (aw_hs) begin
            aw_held_reg <= 1'b1;
            awaddr_reg <= s_axi_awaddr;
        end else if (wr_go) begin
            aw_held_reg <= 1'b0;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            w_held_reg <= 1'b0;
            wdata_reg <= 32'h0000_0000;
            wstrb_reg <= 4'h0;
        end else if (w_hs) begin
            w_held_reg <= 1'b1;
            wdata_reg <= s_axi_wdata;
            wstrb_reg <= s_axi_wstrb;
        end else if (wr_go) begin
            w_held_reg <= 1'b0;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            bvalid_reg <= 1'b0;
            bresp_reg <= mmp_pkg::RESP_OKAY;
        end else if (wr_go) begin
            bvalid_reg <= 1'b1;
            bresp_reg <= w_hit ? mmp_pkg::RESP_OKAY : mmp_pkg::RESP_SLVERR;
        end else if (s_axi_bready) begin
            bvalid_reg <= 1'b0;
        end
    end

    genvar g;
    for (g = 0; g < mmp_pkg::REG_COUNT; g++) begin : g_reg
        localparam logic [7:0] RST = (g == int'(mmp_pkg::IDX_PORT_C_OPTION)) ?
                                     mmp_pkg::RST_PORT_C_OPTION : mmp_pkg::RST_ZERO;
        always_ff @(posedge clk_i or negedge rst_n_i) begin
            if (!rst_n_i) begin
                regs_reg[g] <= RST;
            end else if (w_port_we && (w_idx == 10'(g))) begin
                regs_reg[g] <= wd[7:0];
            end
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            dec_addr_reg <= mmp_pkg::REG_BASE;
            sect0_base_reg <= SECT0_BASE_RST;
            flash_base_reg <= FLASH_BASE_RST;
        end else if (wr_go) begin
            if (wa == mmp_pkg::OFF_DECODE_ADDR) begin
                if (ws[0]) dec_addr_reg[7:0] <= wd[7:0];
                if (ws[1]) dec_addr_reg[15:8] <= wd[15:8];
            end else if (wa == mmp_pkg::OFF_SECT0_BASE) begin
                if (ws[0]) sect0_base_reg[7:0] <= wd[7:0];
                if (ws[1]) sect0_base_reg[15:8] <= wd[15:8];
            end else if (wa == mmp_pkg::OFF_FLASH_BASE) begin
                if (ws[0]) flash_base_reg[7:0] <= wd[7:0];
                if (ws[1]) flash_base_reg[15:8] <= wd[15:8];
            end
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            region_reg <= 8'h00;
        end else begin
            region_reg <= dif.region;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rvalid_reg <= 1'b0;
            rdata_reg <= 32'h0000_0000;
            rresp_reg <= mmp_pkg::RESP_OKAY;
        end else if (ar_hs) begin
            rvalid_reg <= 1'b1;
            rdata_reg <= r_val;
            rresp_reg <= r_ok ? mmp_pkg::RESP_OKAY : mmp_pkg::RESP_SLVERR;
        end else if (s_axi_rready) begin
            rvalid_reg <= 1'b0;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            s_axi_awready <= 1'b0;
        end else begin
            s_axi_awready <= awready_next;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            s_axi_wready <= 1'b0;
        end else begin
            s_axi_wready <= wready_next;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            s_axi_arready <= 1'b0;
        end else begin
            s_axi_arready <= arready_next;
        end
    end

    assign s_axi_bvalid = bvalid_reg;
    assign s_axi_bresp = bresp_reg;
    assign s_axi_rvalid = rvalid_reg;
    assign s_axi_rdata = rdata_reg;
    assign s_axi_rresp = rresp_reg;
    assign port_a_data_o = regs_reg[mmp_pkg::IDX_PORT_A_DATA];
    assign port_a_direction_o = regs_reg[mmp_pkg::IDX_PORT_A_DIRECTION];
    assign port_a_option_o = regs_reg[mmp_pkg::IDX_PORT_A_OPTION];
    assign port_b_data_o = regs_reg[mmp_pkg::IDX_PORT_B_DATA];
    assign port_b_direction_o = regs_reg[mmp_pkg::IDX_PORT_B_DIRECTION];
    assign port_b_option_o = regs_reg[mmp_pkg::IDX_PORT_B_OPTION];
    assign port_c_data_o = regs_reg[mmp_pkg::IDX_PORT_C_DATA];
    assign port_c_direction_o = regs_reg[mmp_pkg::IDX_PORT_C_DIRECTION];
    assign port_c_option_o = regs_reg[mmp_pkg::IDX_PORT_C_OPTION];
    assign region_o = region_reg;

    sequence s_ar_taken;
        s_axi_arvalid && s_axi_arready;
    endsequence

    sequence s_answer_waiting;
        s_axi_rvalid && !s_axi_rready;
    endsequence

    sequence s_write_complete;
        aw_held_reg && w_held_reg && !bvalid_reg;
    endsequence

    property p_awready_pulse;
        @(posedge clk_i) disable iff (!rst_n_i)
        s_axi_awready |=> !s_axi_awready;
    endproperty
    a_awready_pulse: assert property (p_awready_pulse) else $error("awready stood two cycles");

    property p_wready_pulse;
        @(posedge clk_i) disable iff (!rst_n_i)
        s_axi_wready |=> !s_axi_wready;
    endproperty
    a_wready_pulse: assert property (p_wready_pulse) else $error("wready stood two cycles");

    property p_arready_pulse;
        @(posedge clk_i) disable iff (!rst_n_i)
        s_axi_arready |=> !s_axi_arready;
    endproperty
    a_arready_pulse: assert property (p_arready_pulse) else $error("arready stood two cycles");

    property p_read_answer;
        @(posedge clk_i) disable iff (!rst_n_i)
        s_ar_taken |=> s_axi_rvalid;
    endproperty
    a_read_answer: assert property (p_read_answer) else $error("read not answered next cycle");

    property p_read_holds;
        @(posedge clk_i) disable iff (!rst_n_i)
        s_answer_waiting |=> s_axi_rvalid && $stable(s_axi_rdata);
    endproperty
    a_read_holds: assert property (p_read_holds) else $error("read answer dropped before taken");

    property p_write_answer;
        @(posedge clk_i) disable iff (!rst_n_i)
        s_write_complete |=> s_axi_bvalid;
    endproperty
    a_write_answer: assert property (p_write_answer) else $error("write not answered next cycle");

    property p_port_a_data_write;
        @(posedge clk_i) disable iff (!rst_n_i)
        w_port_we && (w_idx == 10'(mmp_pkg::IDX_PORT_A_DATA)) |=> port_a_data_o == $past(wd[7:0]);
    endproperty
    a_port_a_data_write: assert property (p_port_a_data_write) else $error("port A data write lost");

    property p_port_b_data_write;
        @(posedge clk_i) disable iff (!rst_n_i)
        w_port_we && (w_idx == 10'(mmp_pkg::IDX_PORT_B_DATA)) |=> port_b_data_o == $past(wd[7:0]);
    endproperty
    a_port_b_data_write: assert property (p_port_b_data_write) else $error("port B data write lost");

    property p_port_c_option_write;
        @(posedge clk_i) disable iff (!rst_n_i)
        w_port_we && (w_idx == 10'(mmp_pkg::IDX_PORT_C_OPTION)) |=> port_c_option_o == $past(wd[7:0]);
    endproperty
    a_port_c_option_write: assert property (p_port_c_option_write) else $error("port C option write lost");

    property p_region_reg;
        @(posedge clk_i) disable iff (!rst_n_i)
        (dec_addr_reg <= mmp_pkg::REG_LAST) |=> region_o[mmp_pkg::RG_REG] && !region_o[mmp_pkg::RG_RSVD];
    endproperty
    a_region_reg: assert property (p_region_reg) else $error("register space not decoded");

    property p_region_ram;
        @(posedge clk_i) disable iff (!rst_n_i)
        (dec_addr_reg >= mmp_pkg::RAM_BASE) && (dec_addr_reg <= mmp_pkg::RAM_LAST)
        |=> region_o[mmp_pkg::RG_RAM] && !region_o[mmp_pkg::RG_REG];
    endproperty
    a_region_ram: assert property (p_region_ram) else $error("RAM space not decoded");

    property p_stack_in_ram;
        @(posedge clk_i) disable iff (!rst_n_i)
        (dec_addr_reg >= mmp_pkg::STACK_BASE) && (dec_addr_reg <= mmp_pkg::STACK_LAST)
        |=> region_o[mmp_pkg::RG_STACK] && region_o[mmp_pkg::RG_RAM];
    endproperty
    a_stack_in_ram: assert property (p_stack_in_ram) else $error("stack not inside RAM");

    property p_vector_sect0;
        @(posedge clk_i) disable iff (!rst_n_i)
        (dec_addr_reg >= mmp_pkg::VECT_BASE) && (sect0_base_reg <= mmp_pkg::VECT_BASE)
        && (flash_base_reg <= sect0_base_reg) |=> region_o[mmp_pkg::RG_VECT] && region_o[mmp_pkg::RG_SECT0];
    endproperty
    a_vector_sect0: assert property (p_vector_sect0) else $error("vectors outside sector zero");

    property p_sect1_below_boundary;
        @(posedge clk_i) disable iff (!rst_n_i)
        (dec_addr_reg >= flash_base_reg) && (dec_addr_reg < sect0_base_reg)
        |=> region_o[mmp_pkg::RG_SECT1] && !region_o[mmp_pkg::RG_SECT0];
    endproperty
    a_sect1_below_boundary: assert property (p_sect1_below_boundary) else $error("sector boundary ignored");
endmodule

// >>> verification/mmp_cpu_master.sv
`timescale 1ns/1ns
module mmp_cpu_master (
    input wire logic clk_i,
    output logic [11:0] s_axi_awaddr = 12'h000,
    output logic s_axi_awvalid = 1'b0,
    input wire logic s_axi_awready,
    output logic [31:0] s_axi_wdata = 32'h0000_0000,
    output logic [3:0] s_axi_wstrb = 4'hF,
    output logic s_axi_wvalid = 1'b0,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    output logic s_axi_bready = 1'b0,
    output logic [11:0] s_axi_araddr = 12'h000,
    output logic s_axi_arvalid = 1'b0,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    output logic s_axi_rready = 1'b0
);
    int lag = 0;
    logic hung = 1'b0;
    // Whole word write (all four strobes set), released lines show the inverse
    // Reserved map space is only probed through the decoder, never addressed
    task automatic wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
        int n = 0;
        logic aw = 1'b0;
        logic w = 1'b0;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        do begin
            @(posedge clk_i);
            n++;
            aw = aw | s_axi_awready;
            w = w | s_axi_wready;
            if (aw) begin
                s_axi_awvalid <= 1'b0;
                s_axi_awaddr <= ~a;
            end
            if (w) begin
                s_axi_wvalid <= 1'b0;
                s_axi_wdata <= ~d;
            end
        end while (!(aw && w) && n < 200);
        repeat (lag) @(posedge clk_i);
        s_axi_bready <= 1'b1;
        do begin
            @(posedge clk_i);
            n++;
        end while (!s_axi_bvalid && n < 400);
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
        hung = hung | (n >= 400);
    endtask
    task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
        int n = 0;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do begin
            @(posedge clk_i);
            n++;
        end while (!s_axi_arready && n < 200);
        s_axi_arvalid <= 1'b0;
        s_axi_araddr <= ~a;
        repeat (lag) @(posedge clk_i);
        s_axi_rready <= 1'b1;
        do begin
            @(posedge clk_i);
            n++;
        end while (!s_axi_rvalid && n < 400);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
        hung = hung | (n >= 400);
    endtask
endmodule

// >>> verification/test_memory_map_port_regs.sv
`timescale 1ns/1ns
module test_memory_map_port_regs;
    logic clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic [11:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, d;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp, r;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [7:0] port_o [9];
    logic [7:0] region_o;
    int error_cnt = 0;
    int samples_checked = 0;
    always #20 clk_i = ~clk_i;
    mmp_top DUT (
        .clk_i, .rst_n_i, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
        .port_a_data_o(port_o[0]), .port_a_direction_o(port_o[1]), .port_a_option_o(port_o[2]),
        .port_b_data_o(port_o[3]), .port_b_direction_o(port_o[4]), .port_b_option_o(port_o[5]),
        .port_c_data_o(port_o[6]), .port_c_direction_o(port_o[7]), .port_c_option_o(port_o[8]),
        .region_o
    );
    mmp_cpu_master cpu (
        .clk_i, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready
    );
    task automatic conclude();
        $display("checks %0d errors %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
        if (cpu.hung) begin
            error_cnt++;
            $display("mismatch at %0t: bus answer never came", $time);
            conclude();
        end
    endtask
    // Decode one address, compare the region bit vector on the bus and the port
    task automatic dec(input logic [15:0] a, input logic [7:0] m);
        cpu.wr(mmp_pkg::OFF_DECODE_ADDR, {16'h0000, a}, r);
        chk(r, mmp_pkg::RESP_OKAY);
        cpu.rd(mmp_pkg::OFF_DECODE_RESULT, d, r);
        chk({d[7:0], region_o}, {2{m}});
    endtask
    initial begin
        repeat (20) @(posedge clk_i);
        rst_n_i <= 1'b1;
        @(posedge clk_i);
        for (int i = 0; i < 9; i++) begin
            cpu.rd(12'(4 * i), d, r);
            chk({r, d[7:0]}, {mmp_pkg::RESP_OKAY, (i == 8) ? 8'h08 : 8'h00});
            cpu.lag = i % 3;
            cpu.wr(12'(4 * i), {24'hFF_FFFF, 8'(8'hA0 + i)}, r);
            chk(r, mmp_pkg::RESP_OKAY);
        end
        cpu.lag = 0;
        cpu.wr(12'h024, 32'h0000_00FF, r);
        chk(r, mmp_pkg::RESP_SLVERR);
        cpu.rd(12'h024, d, r);
        chk(r, mmp_pkg::RESP_SLVERR);
        for (int i = 0; i < 9; i++) begin
            cpu.rd(12'(4 * i), d, r);
            chk({port_o[i], d[7:0]}, {2{8'(8'hA0 + i)}});
        end
        dec(16'h0000, 8'h01);
        dec(16'h007F, 8'h01);
        dec(16'h0080, 8'h02);
        dec(16'h0180, 8'h06);
        dec(16'h01FF, 8'h06);
        dec(16'h0200, 8'h80);
        dec(16'hE000, 8'h28);
        dec(16'hFFDF, 8'h18);
        dec(16'hFFE0, 8'h58);
        dec(16'hFFFF, 8'h58);
        cpu.wr(mmp_pkg::OFF_SECT0_BASE, 32'h0000_E800, r);
        chk(r, mmp_pkg::RESP_OKAY);
        dec(16'hE800, 8'h18);
        dec(16'hE7FF, 8'h28);
        cpu.wr(mmp_pkg::OFF_FLASH_BASE, 32'h0000_F000, r);
        chk(r, mmp_pkg::RESP_OKAY);
        dec(16'hEFFF, 8'h80);
        dec(16'hF000, 8'h18);
        rst_n_i <= 1'b0;
        @(posedge clk_i);
        chk({port_o[0], port_o[8], region_o}, {8'h00, 8'h08, 8'h00});
        rst_n_i <= 1'b1;
        @(posedge clk_i);
        cpu.rd(mmp_pkg::OFF_SECT0_BASE, d, r);
        chk(d[15:0], 16'hF000);
        cpu.rd(mmp_pkg::OFF_FLASH_BASE, d, r);
        chk(d[15:0], 16'hE000);
        conclude();
    end
endmodule
